// ---- design/porc_pkg.sv ----
// package: layout of the pin readback and override register
package porc_pkg;
    localparam logic [7:0] REG_ADDR       = 8'h02;
    localparam int         REG_W          = 24;
    localparam logic [23:0] REG_RESET     = 24'h00_0000;
    localparam int         B_CLK_B_OVR    = 10;
    localparam int         B_CLK_B_ON     = 11;
    localparam int         B_CLK_C_OVR    = 12;
    localparam int         B_CLK_C_ON     = 13;
    localparam int         B_CLK_D_OVR    = 14;
    localparam int         B_CLK_D_ON     = 15;
    localparam int         B_REF_OVR      = 16;
    localparam int         B_REF_ON       = 17;
    localparam int         B_RST_UNLOCK   = 18;
    localparam int         B_CHIP_RST     = 19;
    localparam int         LOW_W          = 10;
    localparam int         NUM_PINS       = 4;
endpackage : porc_pkg

// ---- design/porc_top.sv ----
// upper part of the pin readback and override register
`timescale 1ns/1ps
module porc_top (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic [23:0] reg_wdata,
    output logic      [23:0] reg_rdata,
    // low bits owned elsewhere, shown in readback
    input  wire logic [9:0]  low_bits,
    // loop state
    input  wire logic        second_synth_loop,
    // enable pins
    input  wire logic        ref_buffer_pin,
    input  wire logic        clk_out_b_pin,
    input  wire logic        clk_out_c_pin,
    input  wire logic        clk_out_d_pin,
    // driver enables and chip reset
    output logic             ref_buffer_en,
    output logic             clk_out_b_en,
    output logic             clk_out_c_en,
    output logic             clk_out_d_en,
    output logic             chip_reset
);
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic       chip_reset_bit;
    logic       chip_reset_unlock;
    logic       ref_buffer_override;
    logic       ref_buffer_on_bit;
    logic       clk_out_b_override;
    logic       clk_out_b_on_bit;
    logic       clk_out_c_override;
    logic       clk_out_c_on_bit;
    logic       clk_out_d_override;
    logic       clk_out_d_on_bit;
    logic       wr_hit;
    logic       next_ref_buffer_en;
    logic       next_clk_out_b_en;
    logic       next_clk_out_c_en;
    logic       next_clk_out_d_en;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pin_meta <= 4'h0;
            pin_sync <= 4'h0;
        end else begin
            pin_meta <= {clk_out_d_pin, clk_out_c_pin, clk_out_b_pin,
                         ref_buffer_pin};
            pin_sync <= pin_meta;
        end
    end

    assign wr_hit = reg_wr && (reg_addr == porc_pkg::REG_ADDR);

    // reset bits only change by a write
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            chip_reset_bit    <= 1'b0;
            chip_reset_unlock <= 1'b0;
        end else if (wr_hit) begin
            chip_reset_bit    <= reg_wdata[porc_pkg::B_CHIP_RST];
            chip_reset_unlock <= reg_wdata[porc_pkg::B_RST_UNLOCK];
        end
    end

    // override bits and on bits, all stored on every write to REG_ADDR whatever the override
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ref_buffer_override <= 1'b0;
            ref_buffer_on_bit   <= 1'b0;
            clk_out_b_override  <= 1'b0;
            clk_out_b_on_bit    <= 1'b0;
            clk_out_c_override  <= 1'b0;
            clk_out_c_on_bit    <= 1'b0;
            clk_out_d_override  <= 1'b0;
            clk_out_d_on_bit    <= 1'b0;
        end else if (wr_hit) begin
            ref_buffer_override <= reg_wdata[porc_pkg::B_REF_OVR];
            ref_buffer_on_bit   <= reg_wdata[porc_pkg::B_REF_ON];
            clk_out_b_override  <= reg_wdata[porc_pkg::B_CLK_B_OVR];
            clk_out_b_on_bit    <= reg_wdata[porc_pkg::B_CLK_B_ON];
            clk_out_c_override  <= reg_wdata[porc_pkg::B_CLK_C_OVR];
            clk_out_c_on_bit    <= reg_wdata[porc_pkg::B_CLK_C_ON];
            clk_out_d_override  <= reg_wdata[porc_pkg::B_CLK_D_OVR];
            clk_out_d_on_bit    <= reg_wdata[porc_pkg::B_CLK_D_ON];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            chip_reset <= 1'b0;
        end else begin
            chip_reset <= chip_reset_bit && chip_reset_unlock;
        end
    end

    always_comb begin
        next_ref_buffer_en = ref_buffer_override ? ref_buffer_on_bit
                                                 : pin_sync[0];
        next_clk_out_b_en = second_synth_loop &&
            (clk_out_b_override ? clk_out_b_on_bit : pin_sync[1]);
        next_clk_out_c_en = second_synth_loop &&
            (clk_out_c_override ? clk_out_c_on_bit : pin_sync[2]);
        next_clk_out_d_en = second_synth_loop &&
            (clk_out_d_override ? clk_out_d_on_bit : pin_sync[3]);
    end

    // registered driver enables keep outputs glitch free
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ref_buffer_en <= 1'b0;
            clk_out_b_en  <= 1'b0;
            clk_out_c_en  <= 1'b0;
            clk_out_d_en  <= 1'b0;
        end else begin
            ref_buffer_en <= next_ref_buffer_en;
            clk_out_b_en  <= next_clk_out_b_en;
            clk_out_c_en  <= next_clk_out_c_en;
            clk_out_d_en  <= next_clk_out_d_en;
        end
    end

    // readback; other addresses read zero
    always_comb begin
        reg_rdata = porc_pkg::REG_RESET;
        if (reg_addr == porc_pkg::REG_ADDR) begin
            reg_rdata[porc_pkg::B_CHIP_RST]   = chip_reset_bit;
            reg_rdata[porc_pkg::B_RST_UNLOCK] = chip_reset_unlock;
            reg_rdata[porc_pkg::B_REF_OVR]    = ref_buffer_override;
            reg_rdata[porc_pkg::B_REF_ON]     = ref_buffer_override ?
                ref_buffer_on_bit : pin_sync[0];
            reg_rdata[porc_pkg::B_CLK_D_OVR]  = clk_out_d_override;
            reg_rdata[porc_pkg::B_CLK_D_ON]   = clk_out_d_override ?
                clk_out_d_on_bit : pin_sync[3];
            reg_rdata[porc_pkg::B_CLK_C_OVR]  = clk_out_c_override;
            reg_rdata[porc_pkg::B_CLK_C_ON]   = clk_out_c_override ?
                clk_out_c_on_bit : pin_sync[2];
            reg_rdata[porc_pkg::B_CLK_B_OVR]  = clk_out_b_override;
            reg_rdata[porc_pkg::B_CLK_B_ON]   = clk_out_b_override ?
                clk_out_b_on_bit : pin_sync[1];
            reg_rdata[porc_pkg::LOW_W-1:0]    = low_bits;
        end
    end

    chk_reset_needs_unlock: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        chip_reset |-> $past(chip_reset_bit && chip_reset_unlock))
        else $error("chip reset without both bits");
    chk_reset_no_self_clear: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (chip_reset_bit && !wr_hit) |=> chip_reset_bit)
        else $error("chip reset bit cleared itself");
    chk_reset_locked_off: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !chip_reset_unlock |=> !chip_reset)
        else $error("chip reset while locked");
    chk_ref_override_on: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        ref_buffer_override |=> ref_buffer_en == $past(ref_buffer_on_bit))
        else $error("reference enable ignores on bit");
    chk_ref_pin_mirror: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!ref_buffer_override && reg_addr == porc_pkg::REG_ADDR) |->
        reg_rdata[porc_pkg::B_REF_ON] == pin_sync[0])
        else $error("reference readback not pin");
    chk_d_pin_path: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!clk_out_d_override && second_synth_loop) |=>
        clk_out_d_en == $past(pin_sync[3]))
        else $error("fourth enable not pin");
    chk_d_loop_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !second_synth_loop |=> !clk_out_d_en)
        else $error("fourth on with loop off");
    chk_c_loop_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !second_synth_loop |=> !clk_out_c_en)
        else $error("third on with loop off");
    chk_b_override_on: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (clk_out_b_override && second_synth_loop) |=>
        clk_out_b_en == $past(clk_out_b_on_bit))
        else $error("second enable ignores on bit");
    chk_top_nibble_zero: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        reg_rdata[23:20] == 4'h0)
        else $error("unused bits nonzero");
    chk_reset_follows_bits: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (chip_reset_bit && chip_reset_unlock) |=> chip_reset)
        else $error("chip reset missing with both bits");
    chk_reset_bit_store: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        wr_hit |=> chip_reset_bit == $past(reg_wdata[porc_pkg::B_CHIP_RST]))
        else $error("chip reset bit not stored");
    chk_ref_pin_path: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !ref_buffer_override |=> ref_buffer_en == $past(pin_sync[0]))
        else $error("reference enable not pin");
    chk_d_override_on: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (clk_out_d_override && second_synth_loop) |=>
        clk_out_d_en == $past(clk_out_d_on_bit))
        else $error("fourth enable ignores on bit");
    chk_d_pin_mirror: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!clk_out_d_override && reg_addr == porc_pkg::REG_ADDR) |->
        reg_rdata[porc_pkg::B_CLK_D_ON] == pin_sync[3])
        else $error("fourth readback not pin");
    chk_c_override_on: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (clk_out_c_override && second_synth_loop) |=>
        clk_out_c_en == $past(clk_out_c_on_bit))
        else $error("third enable ignores on bit");
    chk_c_pin_mirror: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!clk_out_c_override && reg_addr == porc_pkg::REG_ADDR) |->
        reg_rdata[porc_pkg::B_CLK_C_ON] == pin_sync[2])
        else $error("third readback not pin");
    chk_b_pin_mirror: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!clk_out_b_override && reg_addr == porc_pkg::REG_ADDR) |->
        reg_rdata[porc_pkg::B_CLK_B_ON] == pin_sync[1])
        else $error("second readback not pin");
    chk_b_loop_gate: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        !second_synth_loop |=> !clk_out_b_en)
        else $error("second on with loop off");
    chk_b_pin_path: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!clk_out_b_override && second_synth_loop) |=>
        clk_out_b_en == $past(pin_sync[1]))
        else $error("second enable not pin");
    chk_addr_decode: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_wr && reg_addr != porc_pkg::REG_ADDR) |=>
        $stable({chip_reset_bit, chip_reset_unlock, ref_buffer_override,
                 ref_buffer_on_bit, clk_out_d_override, clk_out_d_on_bit}))
        else $error("write to other address took effect");
    chk_pin_two_stage: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!$past(sys_rst) && !$past(sys_rst, 2)) |->
        pin_sync == $past({clk_out_d_pin, clk_out_c_pin, clk_out_b_pin,
                           ref_buffer_pin}, 2))
        else $error("pin sync latency wrong");

    cov_chip_reset: cover property (@(posedge sys_clk) chip_reset);
    cov_ref_override: cover property (
        @(posedge sys_clk) ref_buffer_override && ref_buffer_en);
    cov_d_pin_on: cover property (
        @(posedge sys_clk) !clk_out_d_override && clk_out_d_en);
    cov_loop_blocks: cover property (
        @(posedge sys_clk) !second_synth_loop && clk_out_b_override);
    cov_other_write: cover property (
        @(posedge sys_clk) reg_wr && reg_addr != porc_pkg::REG_ADDR);
endmodule : porc_top

// ---- verif/porc_board_model.sv ----
// board logic model driving the four output-enable pins
`timescale 1ns/1ps
module porc_board_model (
    // clock
    input  wire logic       sys_clk,
    // requested pin levels, order d c b ref
    input  wire logic [3:0] want,
    // enable pins
    output logic            ref_buffer_pin,
    output logic            clk_out_b_pin,
    output logic            clk_out_c_pin,
    output logic            clk_out_d_pin
);
    logic [3:0] lvl = 4'h0;
    // pins move off the sampling edge so the synchroniser sees clean levels
    always @(negedge sys_clk) begin
        lvl <= want;
    end
    assign {clk_out_d_pin, clk_out_c_pin, clk_out_b_pin,
            ref_buffer_pin} = lvl;
endmodule : porc_board_model

// ---- verif/porc_top_tb.sv ----
// self-checking bench for the pin readback and override register
`timescale 1ns/1ps
module porc_top_tb;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic [23:0] reg_wdata = 24'h00_0000;
    logic [23:0] reg_rdata;
    logic [9:0]  low_bits = 10'h000;
    logic        second_synth_loop = 1'b0;
    logic [3:0]  want = 4'h0;
    logic        ref_buffer_pin, clk_out_b_pin, clk_out_c_pin, clk_out_d_pin;
    logic        ref_buffer_en, clk_out_b_en, clk_out_c_en, clk_out_d_en;
    logic        chip_reset;
    logic        probe = 1'b0;
    logic [23:0] sh = 24'h00_0000;
    logic [28:0] exp_v;
    logic [28:0] exp_q[$];
    int          fail_count = 0;
    int          check_count = 0;
    logic [23:0] dir_tab[4] = '{24'h0C_0000, 24'h04_0000,
                                24'h08_0000, 24'h00_0000};

    porc_top u_porc_top (.sys_clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rdata, .low_bits, .second_synth_loop, .ref_buffer_pin,
        .clk_out_b_pin, .clk_out_c_pin, .clk_out_d_pin, .ref_buffer_en,
        .clk_out_b_en, .clk_out_c_en, .clk_out_d_en, .chip_reset);
    porc_board_model u_porc_board_model (.sys_clk, .want, .ref_buffer_pin,
        .clk_out_b_pin, .clk_out_c_pin, .clk_out_d_pin);

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    // expected outputs from the shadow, the requested pins and the loop
    function automatic logic [28:0] expect_f(input logic [7:0] a);
        logic [23:0] r;
        logic        rf, b, c, d;
        rf = sh[16] ? sh[17] : want[0];
        b = sh[10] ? sh[11] : want[1];
        c = sh[12] ? sh[13] : want[2];
        d = sh[14] ? sh[15] : want[3];
        r = {4'h0, sh[19:18], rf, sh[16], d, sh[14], c, sh[12], b, sh[10],
             low_bits};
        if (a != porc_pkg::REG_ADDR) begin
            r = 24'h00_0000;
        end
        return {sh[19] & sh[18], d & second_synth_loop,
                c & second_synth_loop, b & second_synth_loop, rf, r};
    endfunction : expect_f

    task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        if (a == porc_pkg::REG_ADDR) begin
            sh[19:10] = d[19:10];
        end
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask : wr_reg

    // settle past the synchroniser and output register, then note a check
    task automatic chk(input logic [7:0] a);
        repeat (4) @(negedge sys_clk);
        reg_addr = a;
        exp_q.push_back(expect_f(a));
        probe = 1'b1;
        @(negedge sys_clk);
        probe = 1'b0;
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    always @(posedge sys_clk) begin
        if (probe) begin
            exp_v = exp_q.pop_front();
            check_count++;
            if ({chip_reset, clk_out_d_en, clk_out_c_en, clk_out_b_en,
                 ref_buffer_en, reg_rdata} !== exp_v) begin
                fail_count++;
                $display("mismatch at %0t: expected %h", $time, exp_v);
            end
        end
    end

    initial begin
        logic [7:0] wa;
        void'($urandom(56));
        repeat (16) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk(porc_pkg::REG_ADDR);
        second_synth_loop = 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr_reg(porc_pkg::REG_ADDR, dir_tab[i]);
            chk(porc_pkg::REG_ADDR);
        end
        // random pins, loop state and writes, some to other addresses
        for (int i = 0; i < 40; i++) begin
            low_bits = 10'($urandom);
            second_synth_loop = 1'($urandom);
            want = 4'($urandom);
            wa = ($urandom % 4 == 0) ? 8'h02 ^ (8'h01 << ($urandom % 8))
                                     : porc_pkg::REG_ADDR;
            wr_reg(wa, 24'($urandom));
            chk(porc_pkg::REG_ADDR);
            chk(8'h02 ^ (8'h01 << ($urandom % 8)));
        end
        // second reset mid-run must clear every stored bit
        sys_rst = 1'b1;
        sh = 24'h00_0000;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        chk(porc_pkg::REG_ADDR);
        end_sim();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #(4 * 3000);
        fail_count++;
        end_sim();
    end
endmodule : porc_top_tb
